// [test/pa_model.sv]
// amplifier stand-in: carrier cycle ticks and a load-dependent supply
`timescale 1ns/100ps
module pa_model #(
  parameter int TICK_DIV = 4
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // envelope from the shaper
  input wire logic [7:0] i_envelope,
  // carrier and supply feedback
  output logic o_carrier_tick,
  output logic [7:0] o_supply
);
  logic [7:0] div_reg;

  // one tick per carrier cycle, the shaping clock
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      div_reg <= 8'h00;
      o_carrier_tick <= 1'b0;
    end else begin
      div_reg <= (div_reg == 8'(TICK_DIV - 1)) ? 8'h00 : div_reg + 8'h01;
      o_carrier_tick <= (div_reg == 8'(TICK_DIV - 1));
    end
  end

  // supply sags under load, so supply styles see a level that falls as the envelope rises past 0x07
  assign o_supply = 8'h90 - {3'h0, i_envelope[7:3]};
endmodule

// [test/tb_tx_edge_shaper.sv]
// self-checking bench for the transmitter edge shaper
`timescale 1ns/100ps
module tb_tx_edge_shaper;
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr_en = 1'b0;
  logic i_rd_en = 1'b0;
  logic i_mod_active = 1'b0;
  logic i_type_f = 1'b0;
  logic i_carrier_tick;
  logic [7:0] i_amplifier_supply_voltage;
  logic [7:0] o_rd_data;
  logic [7:0] o_pa_envelope;
  logic o_edge_busy;
  logic o_edge_falling;
  int failures = 0;
  int checks = 0;
  int ticks = 0;

  // 25 MHz reference clock
  initial begin
    forever #20 i_ref_clk = ~i_ref_clk;
  end

  tx_edge_shaper i_tx_edge_shaper (.i_ref_clk, .i_resetn, .i_addr,
    .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .i_carrier_tick,
    .i_mod_active, .i_type_f, .i_amplifier_supply_voltage, .o_pa_envelope,
    .o_edge_busy, .o_edge_falling);

  pa_model i_pa_model (.i_ref_clk, .i_resetn, .i_envelope(o_pa_envelope),
    .o_carrier_tick(i_carrier_tick), .o_supply(i_amplifier_supply_voltage));

  // carrier ticks seen while a ramp runs
  always @(posedge i_ref_clk) begin
    if (o_edge_busy === 1'b1 && i_carrier_tick === 1'b1) begin
      ticks++;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_en <= 1'b1;
    @(posedge i_ref_clk);
    i_wr_en <= 1'b0;
  endtask

  // masked read, data sampled in the single cycle it stands
  task automatic rdm(input logic [15:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd_en <= 1'b1;
    @(posedge i_ref_clk);
    i_rd_en <= 1'b0;
    #1 chk(o_rd_data & m, e);
  endtask

  task automatic settle();
    repeat (3) @(posedge i_ref_clk);
    #1;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    #1;
    while (o_edge_busy !== 1'b0 && n < 4000) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    // a ramp that never ends counts against the run
    if (n >= 4000) begin
      failures++;
      $display("[ERR] %0t ramp never finished", $time);
    end
  endtask

  // change the modulation level and wait out the ramp
  task automatic level(input logic m);
    @(posedge i_ref_clk);
    i_mod_active <= m;
    ticks = 0;
    repeat (2) @(posedge i_ref_clk);
    wait_idle();
  endtask

  task automatic conclude();
    if (failures == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic s_regs();
    rdm(16'h0031, 8'hff, 8'h11);
    rdm(16'h0033, 8'hff, 8'h04);
    rdm(16'h0034, 8'hff, 8'h00);
    chk(o_pa_envelope, 8'hff);
    wr(16'h0032, 8'hff);
    rdm(16'h0032, 8'hff, 8'h77);
    wr(16'h0033, 8'hff);
    rdm(16'h0033, 8'hff, 8'h9f);
    rdm(16'h0050, 8'hff, 8'h00);
  endtask

  task automatic s_walk();
    int n;
    wr(16'h0031, 8'h11);
    wr(16'h0033, 8'h02);
    wr(16'h0030, 8'h00);
    @(posedge i_ref_clk);
    i_mod_active <= 1'b1;
    n = 0;
    while (o_pa_envelope === 8'hff && n < 100) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    chk(o_pa_envelope, 8'h80);
    wait_idle();
    chk(o_pa_envelope, 8'h00);
    level(1'b0);
    chk(o_pa_envelope, 8'hff);
  endtask

  // four-state linear fall must pass evenly spaced levels
  task automatic s_linear();
    logic [7:0] lv [4];
    logic [7:0] prev;
    int n;
    lv = '{8'hc0, 8'h80, 8'h40, 8'h00};
    wr(16'h0033, 8'h04);
    @(posedge i_ref_clk);
    i_mod_active <= 1'b1;
    #1;
    for (int s = 0; s < 4; s++) begin
      prev = o_pa_envelope;
      n = 0;
      while (o_pa_envelope === prev && n < 100) begin
        @(posedge i_ref_clk);
        #1;
        n++;
      end
      chk(o_pa_envelope, lv[s]);
    end
    wait_idle();
    level(1'b0);
    chk(o_pa_envelope, 8'hff);
  endtask

  task automatic s_styles();
    logic [7:0] t;
    wr(16'h0033, 8'h03);
    wr(16'h0030, 8'h20);
    for (int f = 1; f <= 6; f++) begin
      t = {4'(f), 4'(7 - f)};
      wr(16'h0031, t);
      rdm(16'h0031, 8'hff, t);
      wr(16'h0032, {1'b0, 3'(f % 4), 1'b0, 3'(f % 4)});
      level(1'b1);
      chk(o_pa_envelope, 8'h20);
      rdm(16'h0040, 8'he0, 8'h40);
      level(1'b0);
      chk(o_pa_envelope, 8'hff);
    end
    wr(16'h0031, 8'h71);
    level(1'b1);
    rdm(16'h0040, 8'h20, 8'h20);
    wr(16'h0040, 8'h20);
    rdm(16'h0040, 8'h20, 8'h00);
    level(1'b0);
  endtask

  task automatic s_scale();
    wr(16'h0031, 8'h44);
    wr(16'h0033, 8'h02);
    level(1'b1);
    chk(8'(ticks), 8'h02);
    level(1'b0);
    wr(16'h0033, 8'h82);
    level(1'b1);
    chk(8'(ticks), 8'h04);
    level(1'b0);
    chk(8'(ticks), 8'h04);
    wr(16'h0033, 8'h00);
    level(1'b1);
    chk(8'(ticks), 8'h00);
  endtask

  task automatic s_typef();
    wr(16'h0034, 8'h55);
    wr(16'h0030, 8'h22);
    i_type_f <= 1'b1;
    settle();
    chk(o_pa_envelope, 8'h55);
    i_type_f <= 1'b0;
    settle();
    chk(o_pa_envelope, 8'h22);
    i_type_f <= 1'b1;
    wr(16'h0034, 8'hff);
    settle();
    chk(o_pa_envelope, 8'hff);
    wr(16'h0034, 8'h00);
    settle();
    chk(o_pa_envelope, 8'h00);
    level(1'b0);
  endtask

  // watchdog, far beyond the expected run length
  initial begin
    repeat (30000) @(posedge i_ref_clk);
    failures++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    s_regs();
    s_walk();
    s_linear();
    s_styles();
    s_scale();
    s_typef();
    conclude();
  end
endmodule

// [test/tx_edge_shaper_properties.sv]
// port-level assertion checker for the transmitter edge shaper
`timescale 1ns/100ps
module tx_edge_shaper_properties (
  // watched ports of the shaper
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] o_rd_data,
  input wire logic i_carrier_tick,
  input wire logic i_mod_active,
  input wire logic i_type_f,
  input wire logic [7:0] i_amplifier_supply_voltage,
  input wire logic [7:0] o_pa_envelope,
  input wire logic o_edge_busy,
  input wire logic o_edge_falling
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  // read data only in the cycle after a strobe
  chk_rd_idle_zero: assert property (
    !i_rd_en |=> o_rd_data == 8'h00) else $error("read data without strobe");
  chk_rsv_style_zero: assert property (
    i_rd_en && i_addr == 16'h0032 |=> (o_rd_data & 8'h88) == 8'h00)
    else $error("style reserved bits set");
  chk_rsv_len_zero: assert property (
    i_rd_en && i_addr == 16'h0033 |=> (o_rd_data & 8'h60) == 8'h00)
    else $error("length reserved bits set");
  // amplitude may only move on a completed carrier cycle
  chk_hold_no_tick: assert property (
    o_edge_busy && !i_carrier_tick && $stable(i_mod_active)
    |=> $stable(o_pa_envelope)) else $error("envelope moved without tick");
  chk_edge_dir: assert property (
    $changed(i_mod_active) |=> o_edge_falling == $past(i_mod_active))
    else $error("edge direction wrong");
  chk_rise_ends_full: assert property (
    $fell(o_edge_busy) && !o_edge_falling |-> o_pa_envelope == 8'hff)
    else $error("rising edge not full");
  chk_idle_full_carrier: assert property (
    !o_edge_busy && !i_mod_active && !$past(i_mod_active)
    |-> o_pa_envelope == 8'hff) else $error("idle carrier not full");
  chk_status_mirror: assert property (
    i_rd_en && i_addr == 16'h0040 |=> o_rd_data[7:6] ==
    {$past(o_edge_busy), $past(o_edge_falling)}) else $error("status bits");

  cover property ($fell(o_edge_busy) && o_edge_falling);
  cover property ($fell(o_edge_busy) && !o_edge_falling);
  cover property (i_rd_en && i_addr == 16'h0040);
endmodule

bind tx_edge_shaper tx_edge_shaper_properties i_tx_edge_shaper_properties (
  .i_ref_clk, .i_resetn, .i_addr, .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data,
  .i_carrier_tick, .i_mod_active, .i_type_f, .i_amplifier_supply_voltage,
  .o_pa_envelope, .o_edge_busy, .o_edge_falling);

// [verilog/edge_curve_if.sv]
// carrier between the shaper sequencer and its curve evaluator
`timescale 1ns/100ps
interface edge_curve_if;
  logic [3:0] style;
  logic [2:0] cfg;
  logic [7:0] frac;
  logic [7:0] supply;
  logic [7:0] shaped;
  logic reserved;

  modport seq (output style, cfg, frac, supply, input shaped, reserved);
  modport curve (input style, cfg, frac, supply, output shaped, reserved);
endinterface

// [verilog/tx_edge_curve.sv]
// maps edge progress to shaped progress for one style and setting
`timescale 1ns/100ps
`include "tx_edge_shaper_consts.svh"
module tx_edge_curve (
  // link to sequencer
  edge_curve_if.curve cv
);

  // linear segment from (x0,y0) to (x1,y1); needs x1 > x0, y1 >= y0
  function automatic logic [7:0] seg(input logic [7:0] x, input logic [7:0] x0,
      input logic [7:0] x1, input logic [7:0] y0, input logic [7:0] y1);
    logic [15:0] p;
    // widen both factors first so the product keeps its upper byte
    p = {8'h00, 8'(y1 - y0)} * {8'h00, 8'(x - x0)};
    return 8'(y0 + 8'(p / {8'h00, 8'(x1 - x0)}));
  endfunction

  // square of an eight-bit value scaled down
  function automatic logic [7:0] sq(input logic [7:0] x, input logic s7);
    logic [15:0] p;
    p = {8'h00, x} * {8'h00, x};
    return s7 ? p[14:7] : p[15:8];
  endfunction

  // supply based scaling with saturation
  function automatic logic [7:0] scale(input logic [7:0] y,
      input logic [7:0] num, input logic [7:0] den);
    logic [15:0] p;
    logic [15:0] q;
    p = {8'h00, y} * {8'h00, num};
    q = p / {8'h00, (den == `AMP_ZERO) ? `AMP_FULL : den};
    return (q > {8'h00, `AMP_FULL}) ? `AMP_FULL : q[7:0];
  endfunction

  logic [7:0] h;
  logic [7:0] h2;
  logic [7:0] x;
  logic [7:0] tbl;
  assign x = cv.frac;
  assign h = 8'(`KNEE_BASE + 8'(cv.cfg * `KNEE_STEP));
  assign h2 = {1'b0, h[7:1]};

  // table curves: linear, ease in, ease out, s shape
  always_comb begin
    case (cv.cfg[`LUT_SEL])
      2'h0: tbl = x;
      2'h1: tbl = sq(x, 1'b0);
      2'h2: tbl = 8'(`AMP_FULL - sq(8'(`AMP_FULL - x), 1'b0));
      default: tbl = (x < `S_MID) ? sq(x, 1'b1) :
        8'(`AMP_FULL - sq(8'(`AMP_FULL - x), 1'b1));
    endcase
  end

  // style decode; the time constant sets knee height of segmented ramps
  always_comb begin
    cv.reserved = 1'b0;
    case (cv.style)
      `CODE_FW1: cv.shaped = x;
      `CODE_FW2: cv.shaped = (x < `KNEE_X) ?
        seg(x, `AMP_ZERO, `KNEE_X, `AMP_ZERO, h) :
        seg(x, `KNEE_X, `AMP_FULL, h, `AMP_FULL);
      `CODE_FW3: begin
        if (x < `THIRD_X1) begin
          cv.shaped = seg(x, `AMP_ZERO, `THIRD_X1, `AMP_ZERO, h2);
        end else if (x < `THIRD_X2) begin
          cv.shaped = seg(x, `THIRD_X1, `THIRD_X2, h2, 8'(`AMP_FULL - h2));
        end else begin
          cv.shaped = seg(x, `THIRD_X2, `AMP_FULL, 8'(`AMP_FULL - h2),
            `AMP_FULL);
        end
      end
      `CODE_LUT: cv.shaped = tbl;
      `CODE_LUT_CORR: begin
        cv.shaped = scale(tbl, `SUPPLY_NOMINAL, cv.supply);
      end
      `CODE_LUT_RAW: begin
        cv.shaped = scale(tbl, cv.supply, `SUPPLY_NOMINAL);
      end
      default: begin
        // reserved style: abrupt step rather than an undefined curve
        cv.shaped = `AMP_FULL;
        cv.reserved = 1'b1;
      end
    endcase
  end

endmodule

// [verilog/tx_edge_shaper.sv]
// transmitter edge shaper: config registers and envelope sequencer
`timescale 1ns/100ps
`include "tx_edge_shaper_consts.svh"
module tx_edge_shaper (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // register port
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  // modulation control
  input wire logic i_carrier_tick,
  input wire logic i_mod_active,
  input wire logic i_type_f,
  input wire logic [7:0] i_amplifier_supply_voltage,
  // amplifier side
  output logic [7:0] o_pa_envelope,
  output logic o_edge_busy,
  output logic o_edge_falling
);

  tx_edge_shaper_pkg::state_type s_reg;
  tx_edge_shaper_pkg::state_type s_next;

  edge_curve_if cif ();

  tx_edge_curve u_curve (
    .cv(cif.curve)
  );

  logic [4:0] count;
  logic scaled;
  logic [5:0] k1;
  logic [12:0] num;
  logic [7:0] resid;
  logic edge_start;
  logic last_state;
  logic signed [9:0] diff;
  logic signed [18:0] prod;
  logic signed [18:0] lerp;

  // shared length settings drive both edges
  assign count = s_reg.edge_len[`COUNT_FIELD];
  assign scaled = s_reg.edge_len[`SCALE_BIT];
  assign k1 = 6'({1'b0, s_reg.k} + 6'h01);
  // at or past the count, so a shortened length mid-ramp still ends it
  assign last_state = (k1 >= {1'b0, count});

  // residual level follows the selected card type
  assign resid = i_type_f ? s_reg.res_f : s_reg.res_b;
  assign edge_start = (i_mod_active != s_reg.last_mod);

  // curve inputs; the falling and rising fields are chosen per edge
  always_comb begin
    cif.style = s_reg.falling ? s_reg.edge_type[`FALL_FIELD] :
      s_reg.edge_type[`RISE_FIELD];
    cif.cfg = s_reg.falling ? s_reg.edge_style[`FALL_CFG] :
      s_reg.edge_style[`RISE_CFG];
    cif.supply = i_amplifier_supply_voltage;
    num = {7'h00, k1} * {5'h00, `AMP_FULL};
    if (count == 5'h00) begin
      cif.frac = `AMP_FULL;
    end else begin
      cif.frac = 8'(num / {8'h00, count});
    end
  end

  // interpolate between start and target by shaped progress
  always_comb begin
    diff = signed'({2'b00, s_reg.target}) - signed'({2'b00, s_reg.start});
    prod = 19'(diff * signed'({11'h000, cif.shaped}));
    lerp = 19'(signed'({11'h000, s_reg.start}) + prod / 19'sd255);
  end

  // next state: registers, read data and envelope sequencing
  always_comb begin
    s_next = s_reg;
    s_next.rd_data = `AMP_ZERO;

    // register writes; reserved bits are dropped on the way in
    if (i_wr_en) begin
      case (i_addr)
        `OFS_RES_B: s_next.res_b = i_wr_data;
        `OFS_TYPE: s_next.edge_type = i_wr_data;
        `OFS_STYLE: s_next.edge_style = i_wr_data & `STYLE_MASK;
        `OFS_LEN: s_next.edge_len = i_wr_data & `LEN_MASK;
        `OFS_RES_F: s_next.res_f = i_wr_data;
        `OFS_STATUS: begin
          // write one to clear the config error flag
          if (i_wr_data[`STAT_ERR_BIT]) begin
            s_next.cfg_err = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // reads answer one cycle later; unmapped addresses read zero
    if (i_rd_en) begin
      case (i_addr)
        `OFS_RES_B: s_next.rd_data = s_reg.res_b;
        `OFS_TYPE: s_next.rd_data = s_reg.edge_type;
        `OFS_STYLE: s_next.rd_data = s_reg.edge_style;
        `OFS_LEN: s_next.rd_data = s_reg.edge_len;
        `OFS_RES_F: s_next.rd_data = s_reg.res_f;
        `OFS_STATUS: s_next.rd_data = {
          s_reg.phase == tx_edge_shaper_pkg::ST_RAMP,
          s_reg.falling, s_reg.cfg_err, s_reg.k};
        `OFS_AMP: s_next.rd_data = s_reg.amp;
        default: s_next.rd_data = `AMP_ZERO;
      endcase
    end

    // sequencer: a new edge restarts from the present level
    s_next.last_mod = i_mod_active;
    if (edge_start) begin
      s_next.start = s_reg.amp;
      s_next.target = i_mod_active ? resid : `AMP_FULL;
      s_next.falling = i_mod_active;
      s_next.k = 5'h00;
      s_next.half = 1'b0;
      s_next.edge_cnt = 8'(s_reg.edge_cnt + 8'h01);
      if (count == 5'h00) begin
        // no active states: jump straight to the target
        s_next.amp = s_next.target;
        s_next.phase = tx_edge_shaper_pkg::ST_IDLE;
      end else begin
        s_next.phase = tx_edge_shaper_pkg::ST_RAMP;
      end
    end else begin
      case (s_reg.phase)
        tx_edge_shaper_pkg::ST_RAMP: begin
          if (i_carrier_tick) begin
            if (scaled && !s_reg.half) begin
              s_next.half = 1'b1;
            end else begin
              s_next.half = 1'b0;
              s_next.k = 5'(k1);
              if (cif.reserved) begin
                // set beats a clear in the same cycle
                s_next.cfg_err = 1'b1;
              end
              if (last_state) begin
                s_next.amp = s_reg.target;
                s_next.phase = tx_edge_shaper_pkg::ST_IDLE;
              end else begin
                s_next.amp = lerp[7:0];
              end
            end
          end
        end
        tx_edge_shaper_pkg::ST_IDLE: begin
          // steady modulation follows a changed residual setting
          if (s_reg.last_mod) begin
            s_next.amp = resid;
          end
        end
        default: s_next.phase = tx_edge_shaper_pkg::ST_IDLE;
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      s_reg.res_b <= `RST_RES;
      s_reg.edge_type <= `RST_TYPE;
      s_reg.edge_style <= `RST_STYLE;
      s_reg.edge_len <= `RST_LEN;
      s_reg.res_f <= `RST_RES;
      s_reg.rd_data <= `AMP_ZERO;
      s_reg.amp <= `AMP_FULL;
      s_reg.start <= `AMP_FULL;
      s_reg.target <= `AMP_FULL;
      s_reg.k <= 5'h00;
      s_reg.half <= 1'b0;
      s_reg.falling <= 1'b0;
      s_reg.last_mod <= 1'b0;
      s_reg.cfg_err <= 1'b0;
      s_reg.edge_cnt <= 8'h00;
      s_reg.phase <= tx_edge_shaper_pkg::ST_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from the state register
  assign o_rd_data = s_reg.rd_data;
  assign o_pa_envelope = s_reg.amp;
  assign o_edge_busy = (s_reg.phase == tx_edge_shaper_pkg::ST_RAMP);
  assign o_edge_falling = s_reg.falling;

endmodule

// [verilog/tx_edge_shaper_consts.svh]
// constants and register map of the transmitter edge shaper
// Functional notes
// - falling style in edge-type bits 7:4; codes 1-3 pick 1, 2 or 3 ramps.
// - codes 4-6 pick table shaping: no adaptation, supply correction, scaled by supply.
// - rising style in bits 3:0, same code set, independent of falling.
// - firmware falling edge: bits 6:4 of shape setting give time constant.
// - table falling edge: bits 6:4 of shape setting pick table 0 to 3.
// - firmware rising edge: bits 2:0 give its time constant setting.
// - table rising edge: bits 2:0 pick one of four tables, 0 to 3.
// - duration bit 7 doubles every transition state, both edges together.
// - scaling off means one carrier cycle per state; on means two cycles.
// - duration bits 4:0 give active state count, shared by both edges.
// - Type F 212 residual level sets carrier linearly, 0x00 off, 0xff full.
`ifndef TX_EDGE_SHAPER_CONSTS_SVH
`define TX_EDGE_SHAPER_CONSTS_SVH

// register offsets
`define OFS_RES_B 16'h0030
`define OFS_TYPE 16'h0031
`define OFS_STYLE 16'h0032
`define OFS_LEN 16'h0033
`define OFS_RES_F 16'h0034
`define OFS_STATUS 16'h0040
`define OFS_AMP 16'h0041

// reset values
`define RST_TYPE 8'h11
`define RST_STYLE 8'h00
`define RST_LEN 8'h04
`define RST_RES 8'h00

// field layout
`define STYLE_MASK 8'h77
`define LEN_MASK 8'h9f
`define FALL_FIELD 7:4
`define RISE_FIELD 3:0
`define FALL_CFG 6:4
`define RISE_CFG 2:0
`define LUT_SEL 1:0
`define SCALE_BIT 7
`define COUNT_FIELD 4:0
`define STAT_ERR_BIT 5

// style codes
`define CODE_FW1 4'h1
`define CODE_FW2 4'h2
`define CODE_FW3 4'h3
`define CODE_LUT 4'h4
`define CODE_LUT_CORR 4'h5
`define CODE_LUT_RAW 4'h6

// amplitude and curve shaping points
`define AMP_FULL 8'hff
`define AMP_ZERO 8'h00
`define KNEE_X 8'h80
`define KNEE_BASE 8'h40
`define KNEE_STEP 8'h10
`define THIRD_X1 8'h40
`define THIRD_X2 8'hc0
`define S_MID 8'h80
`define SUPPLY_NOMINAL 8'h80

`endif

// [verilog/tx_edge_shaper_pkg.sv]
// types shared by the transmitter edge shaper
package tx_edge_shaper_pkg;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_RAMP
  } phase_type;

  typedef struct packed {
    logic [7:0] res_b;
    logic [7:0] edge_type;
    logic [7:0] edge_style;
    logic [7:0] edge_len;
    logic [7:0] res_f;
    logic [7:0] rd_data;
    logic [7:0] amp;
    logic [7:0] start;
    logic [7:0] target;
    logic [4:0] k;
    logic half;
    logic falling;
    logic last_mod;
    logic cfg_err;
    logic [7:0] edge_cnt;
    phase_type phase;
  } state_type;

endpackage
